// File: core/pls_pkg.sv
// constants for the power limit and sequencing command bank
package pls_pkg;
   // ----------------------------------------
   // bank layout
   // ----------------------------------------
   localparam int NREG = 26;
   localparam logic [7:0] FORMAT_BYTE_CODE = 8'h20;
   // output voltage format: linear, exponent -13
   localparam logic [7:0] FORMAT_BYTE_VALUE = 8'h13;
   localparam logic [7:0] CODE_TAB [NREG] = '{
      8'h37, 8'h38, 8'h39, 8'h40, 8'h41, 8'h44, 8'h45, 8'h46, 8'h4B,
      8'h4F, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
      8'h58, 8'h59, 8'h5A, 8'h5E, 8'h60, 8'h61, 8'h64, 8'h65};
   // one for a byte-wide setting, zero for a word
   localparam logic [NREG-1:0] BYTE_WIDE = 26'h0114450;
   localparam logic [15:0] RESET_TAB [NREG] = '{
      16'h0000, 16'hC20F, 16'hBD4D, 16'h0000, 16'h0080, 16'h0000,
      16'h0080, 16'hDB00, 16'hDD00, 16'hEBE8, 16'h0080, 16'hEB70,
      16'hE580, 16'hE490, 16'h0080, 16'hD3A0, 16'h0080, 16'hD380,
      16'hCA40, 16'hCA00, 16'h0080, 16'h0000, 16'hCA80, 16'hCA80,
      16'hCA80, 16'hCA80};
   // indexes of settings that matter to the logic
   localparam int IDX_PHASE = 0;
   localparam int IDX_OUT_OV = 3;
   localparam int IDX_OUT_UV = 5;
   localparam int IDX_GOOD = 21;
   localparam int IDX_ON_DLY = 22;
   localparam int IDX_ON_RAMP = 23;
   localparam int IDX_OFF_DLY = 24;
   localparam int IDX_OFF_RAMP = 25;
   // strap scale factors, in percent of the strapped output voltage
   localparam int PCT_OV = 115;
   localparam int PCT_UV = 80;
   localparam int PCT_GOOD = 90;
   localparam int PCT_FULL = 100;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   // sequencing times count in sixteenths of a millisecond
   localparam int TICK_TIME_PS = 62500000;
   localparam int TICK_CYCLES = TICK_TIME_PS / CLK_PERIOD_PS;
   localparam int TICK_SHIFT = 4;
   localparam int TIME_W = 24;
   // ----------------------------------------
   // linear 11-bit field layout
   // ----------------------------------------
   localparam int L11_EXP_MSB = 15;
   localparam int L11_EXP_LSB = 11;
   localparam int L11_MAN_MSB = 10;
   typedef enum logic [2:0] {
      SEQ_OFF, SEQ_ON_WAIT, SEQ_RISE, SEQ_ON, SEQ_OFF_WAIT, SEQ_FALL
   } pls_seq_type;
endpackage

// File: core/pls_regs.sv
// command-addressed limit and sequencing bank with power sequencer
`timescale 1ns/10ps
// Functional notes
// - phase offset word is read/write; default derived from bus address.
// - current sense gain word, linear 11-bit, default C20F.
// - current sense offset word, linear 11-bit, default BD4D.
// - every fault response byte resets to 80, disable without retry.
// - output over/under voltage limits default 1.15 and 0.8 strap voltage.
// - overcurrent fault limit word defaults to DB00.
// - undercurrent fault limit word defaults to DD00.
// - overtemperature fault and warning limits default EBE8 and EB70.
// - undertemperature warning and fault limits default E580 and E490.
// - input overvoltage fault and warning limits default D3A0 and D380.
// - input undervoltage warning and fault limits default CA40 and CA00.
// - power-good threshold defaults to 0.9 times strap voltage.
// - after enable, wait programmable on-delay before raising output.
// - after on-delay, ramp output up over programmable rise time.
// - after disable, wait programmable off-delay before lowering output.
// - after off-delay, lower output over programmable fall time.
// - read-only format byte reports linear mode, exponent -13.
module pls_regs #(
   parameter int TICK_CYC = pls_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // straps
   input wire logic [6:0] BUS_ADDR,
   input wire logic [15:0] VOUT_STRAP,
   // command byte stream from the bus front end
   input wire logic RX_VALID,
   input wire logic RX_START,
   input wire logic [7:0] RX_BYTE,
   input wire logic RX_STOP,
   input wire logic TX_REQ,
   output logic [7:0] TX_BYTE,
   output logic TX_VALID,
   output logic CMD_ERR,
   // sequencing
   input wire logic ENABLE,
   output logic RAMP_UP,
   output logic RAMP_DOWN,
   output logic OUTPUT_ON,
   output logic [15:0] OUT_OV_LIMIT,
   output logic [15:0] OUT_UV_LIMIT,
   output logic [15:0] GOOD_LIMIT,
   output logic [15:0] PHASE_OFFSET
);
   import pls_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] scale(input logic [15:0] v,
                                         input int pct);
      logic [31:0] p;
      p = 32'(v) * 32'(pct) / 32'(PCT_FULL);
      return p[15:0];
   endfunction

   // linear 11-bit time in ms to a count of sixteenth-ms ticks
   function automatic logic [TIME_W-1:0] l11_ticks(input logic [15:0] w);
      logic signed [5:0] sh;
      logic [TIME_W-1:0] m;
      sh = $signed({w[L11_EXP_MSB], w[L11_EXP_MSB:L11_EXP_LSB]})
           + 6'sd4;
      m = TIME_W'(w[L11_MAN_MSB-1:0]);
      if (w[L11_MAN_MSB]) begin
         // negative times mean no wait
         return '0;
      end else if (sh >= 0) begin
         return m << sh;
      end else begin
         return m >> (-sh);
      end
   endfunction

   // ----------------------------------------
   // storage and strap capture
   // ----------------------------------------
   logic [15:0] regs_q [NREG];
   logic strap_load_q;
   logic [7:0] cmd_q;
   logic [1:0] wcnt_q;
   logic [15:0] wdata_q;
   logic cmd_hit;
   logic [4:0] cmd_idx;
   logic commit;

   always_comb begin
      cmd_hit = 1'b0;
      cmd_idx = '0;
      for (int i = 0; i < NREG; i++) begin
         if (CODE_TAB[i] == cmd_q) begin
            cmd_hit = 1'b1;
            cmd_idx = 5'(i);
         end
      end
   end

   // a write lands only if its byte count fits the setting width
   assign commit = RX_STOP && cmd_hit &&
      (BYTE_WIDE[cmd_idx] ? (wcnt_q == 2'd1) : (wcnt_q == 2'd2));

   // straps are sampled on the first clock after reset release
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         strap_load_q <= 1'b1;
      end else begin
         strap_load_q <= 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= RESET_TAB[i];
         end
      end else if (strap_load_q) begin
         regs_q[IDX_PHASE] <= {12'h000, BUS_ADDR[3:0]};
         regs_q[IDX_OUT_OV] <= scale(VOUT_STRAP, PCT_OV);
         regs_q[IDX_OUT_UV] <= scale(VOUT_STRAP, PCT_UV);
         regs_q[IDX_GOOD] <= scale(VOUT_STRAP, PCT_GOOD);
      end else if (commit) begin
         // limits and times write whole, low byte first on the bus
         regs_q[cmd_idx] <= BYTE_WIDE[cmd_idx] ?
            {8'h00, wdata_q[7:0]} : wdata_q;
      end
   end

   // ----------------------------------------
   // command byte stream
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         cmd_q <= 8'h00;
         wcnt_q <= 2'd0;
         wdata_q <= 16'h0000;
      end else if (RX_VALID && RX_START) begin
         cmd_q <= RX_BYTE;
         wcnt_q <= 2'd0;
      end else if (RX_VALID) begin
         if (wcnt_q == 2'd0) begin
            wdata_q[7:0] <= RX_BYTE;
         end else begin
            wdata_q[15:8] <= RX_BYTE;
         end
         // a third byte saturates the count and spoils the write
         if (wcnt_q != 2'd3) begin
            wcnt_q <= wcnt_q + 2'd1;
         end
      end else if (RX_STOP) begin
         wcnt_q <= 2'd0;
      end
   end

   // error pulse for unknown codes or wrong byte counts
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         CMD_ERR <= 1'b0;
      end else begin
         CMD_ERR <= (RX_STOP && wcnt_q != 2'd0 && !commit) ||
                    (TX_REQ && !cmd_hit && cmd_q != FORMAT_BYTE_CODE);
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   logic rd_hi_q;
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         rd_hi_q <= 1'b0;
         TX_BYTE <= 8'h00;
         TX_VALID <= 1'b0;
      end else begin
         TX_VALID <= TX_REQ;
         if (RX_VALID && RX_START) begin
            rd_hi_q <= 1'b0;
         end else if (TX_REQ) begin
            rd_hi_q <= 1'b1;
            if (cmd_q == FORMAT_BYTE_CODE) begin
               TX_BYTE <= FORMAT_BYTE_VALUE;
            end else if (!cmd_hit) begin
               TX_BYTE <= 8'hFF;
            end else if (rd_hi_q) begin
               TX_BYTE <= regs_q[cmd_idx][15:8];
            end else begin
               TX_BYTE <= regs_q[cmd_idx][7:0];
            end
         end
      end
   end

   assign OUT_OV_LIMIT = regs_q[IDX_OUT_OV];
   assign OUT_UV_LIMIT = regs_q[IDX_OUT_UV];
   assign GOOD_LIMIT = regs_q[IDX_GOOD];
   assign PHASE_OFFSET = regs_q[IDX_PHASE];

   // ----------------------------------------
   // tick divider
   // ----------------------------------------
   logic [31:0] div_q;
   logic tick;
   assign tick = (div_q == 32'(TICK_CYC - 1));
   always_ff @(posedge MCLK) begin
      if (!RST_N || tick) begin
         div_q <= 32'h0;
      end else begin
         div_q <= div_q + 32'h1;
      end
   end

   // ----------------------------------------
   // power sequencer
   // ----------------------------------------
   pls_seq_type seq_q;
   logic [TIME_W-1:0] tcnt_q;
   logic done;
   // times are latched at each phase start, so rewrites take effect next
   assign done = (tcnt_q == '0);

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         seq_q <= SEQ_OFF;
         tcnt_q <= '0;
      end else begin
         if (tick && !done) begin
            tcnt_q <= tcnt_q - TIME_W'(1);
         end
         unique case (seq_q)
            SEQ_OFF: begin
               if (ENABLE && !strap_load_q) begin
                  seq_q <= SEQ_ON_WAIT;
                  tcnt_q <= l11_ticks(regs_q[IDX_ON_DLY]);
               end
            end
            SEQ_ON_WAIT: begin
               if (!ENABLE) begin
                  seq_q <= SEQ_OFF;
               end else if (done) begin
                  seq_q <= SEQ_RISE;
                  tcnt_q <= l11_ticks(regs_q[IDX_ON_RAMP]);
               end
            end
            SEQ_RISE: begin
               if (done) begin
                  seq_q <= SEQ_ON;
               end
            end
            SEQ_ON: begin
               if (!ENABLE) begin
                  seq_q <= SEQ_OFF_WAIT;
                  tcnt_q <= l11_ticks(regs_q[IDX_OFF_DLY]);
               end
            end
            SEQ_OFF_WAIT: begin
               if (done) begin
                  seq_q <= SEQ_FALL;
                  tcnt_q <= l11_ticks(regs_q[IDX_OFF_RAMP]);
               end
            end
            SEQ_FALL: begin
               if (done) begin
                  seq_q <= SEQ_OFF;
               end
            end
            default: begin
               seq_q <= SEQ_OFF;
            end
         endcase
      end
   end

   assign RAMP_UP = (seq_q == SEQ_RISE);
   assign RAMP_DOWN = (seq_q == SEQ_FALL);
   assign OUTPUT_ON = (seq_q == SEQ_RISE) || (seq_q == SEQ_ON) ||
                      (seq_q == SEQ_OFF_WAIT) || (seq_q == SEQ_FALL);
endmodule

// File: tb/pls_host.sv
// bus host model feeding the command byte stream
`timescale 1ns/10ps
module pls_host (
   // clock
   input wire logic MCLK,
   // byte stream to the bank
   output logic RX_VALID,
   output logic RX_START,
   output logic [7:0] RX_BYTE,
   output logic RX_STOP,
   output logic TX_REQ,
   // answers
   input wire logic [7:0] TX_BYTE,
   input wire logic CMD_ERR
);
   initial begin
      RX_VALID = 1'b0;
      RX_START = 1'b0;
      RX_BYTE = 8'h00;
      RX_STOP = 1'b0;
      TX_REQ = 1'b0;
   end
   // code, n bytes low first, then commit
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n,
                     output logic err);
      @(posedge MCLK);
      RX_VALID <= 1'b1;
      RX_START <= 1'b1;
      RX_BYTE <= c;
      for (int i = 0; i < n; i++) begin
         @(posedge MCLK);
         RX_START <= 1'b0;
         RX_BYTE <= d[8*i +: 8];
      end
      @(posedge MCLK);
      RX_VALID <= 1'b0;
      RX_START <= 1'b0;
      // released byte inverted so a stale value never looks valid
      RX_BYTE <= ~RX_BYTE;
      RX_STOP <= 1'b1;
      @(posedge MCLK);
      RX_STOP <= 1'b0;
      @(posedge MCLK);
      err = CMD_ERR;
   endtask
   // code, then two read requests, low byte first
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      @(posedge MCLK);
      RX_VALID <= 1'b1;
      RX_START <= 1'b1;
      RX_BYTE <= c;
      for (int i = 0; i < 2; i++) begin
         @(posedge MCLK);
         RX_VALID <= 1'b0;
         RX_START <= 1'b0;
         RX_BYTE <= ~RX_BYTE;
         TX_REQ <= 1'b1;
         @(posedge MCLK);
         TX_REQ <= 1'b0;
         @(posedge MCLK);
         d[8*i +: 8] = TX_BYTE;
      end
   endtask
endmodule

// File: tb/pls_regs_properties.sv
// port-level checker for the limit and sequencing bank
`timescale 1ns/10ps
module pls_regs_properties (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // requests
   input wire logic RX_STOP,
   input wire logic TX_REQ,
   input wire logic ENABLE,
   // answers
   input wire logic TX_VALID,
   input wire logic CMD_ERR,
   input wire logic RAMP_UP,
   input wire logic RAMP_DOWN,
   input wire logic OUTPUT_ON,
   input wire logic [15:0] OUT_OV_LIMIT,
   input wire logic [15:0] GOOD_LIMIT
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   read_answer_a: assert property (TX_REQ |=> TX_VALID)
      else $error("no read byte after request");
   read_cause_a: assert property (TX_VALID |-> $past(TX_REQ))
      else $error("read byte without request");
   err_cause_a: assert property (CMD_ERR |->
      $past(RX_STOP) || $past(TX_REQ))
      else $error("error flag without cause");
   // strap load after reset is the only other legal change
   limit_commit_a: assert property (
      $changed({OUT_OV_LIMIT, GOOD_LIMIT}) |->
      $past(RX_STOP) || !$past(RST_N) || !$past(RST_N, 2))
      else $error("limit changed without commit");
   ramp_excl_a: assert property (!(RAMP_UP && RAMP_DOWN))
      else $error("rising and falling at once");
   rise_start_a: assert property ($rose(OUTPUT_ON) |->
      RAMP_UP && $past(ENABLE))
      else $error("output on without enabled rise");
   fall_end_a: assert property ($fell(OUTPUT_ON) |-> $past(RAMP_DOWN))
      else $error("output off without fall");
   fall_start_a: assert property ($rose(RAMP_DOWN) |->
      $past(OUTPUT_ON) && !$past(RAMP_UP))
      else $error("fall from wrong state");
endmodule
bind pls_regs pls_regs_properties i_props (.MCLK(MCLK), .RST_N(RST_N),
   .RX_STOP(RX_STOP), .TX_REQ(TX_REQ), .ENABLE(ENABLE),
   .TX_VALID(TX_VALID), .CMD_ERR(CMD_ERR), .RAMP_UP(RAMP_UP),
   .RAMP_DOWN(RAMP_DOWN), .OUTPUT_ON(OUTPUT_ON),
   .OUT_OV_LIMIT(OUT_OV_LIMIT), .GOOD_LIMIT(GOOD_LIMIT));

// File: tb/tb.sv
// self-checking bench for the limit and sequencing bank
`timescale 1ns/10ps
module tb;
   import pls_pkg::*;
   localparam int TC = 4;
   logic [6:0] addr;
   logic [15:0] strap;
   logic mclk, rst_n, enable, rx_valid, rx_start, rx_stop, tx_req;
   logic tx_valid, cmd_err, ramp_up, ramp_down, output_on;
   logic [7:0] rx_byte, tx_byte;
   logic [15:0] ov_lim, uv_lim, good_lim, phase;
   int mismatches;
   int checks;
   wire [2:0] st = {output_on, ramp_down, ramp_up};
   pls_regs #(.TICK_CYC(TC)) i_dut (.MCLK(mclk), .RST_N(rst_n),
      .BUS_ADDR(addr), .VOUT_STRAP(strap), .RX_VALID(rx_valid),
      .RX_START(rx_start), .RX_BYTE(rx_byte), .RX_STOP(rx_stop),
      .TX_REQ(tx_req), .TX_BYTE(tx_byte), .TX_VALID(tx_valid),
      .CMD_ERR(cmd_err), .ENABLE(enable), .RAMP_UP(ramp_up),
      .RAMP_DOWN(ramp_down), .OUTPUT_ON(output_on), .OUT_OV_LIMIT(ov_lim),
      .OUT_UV_LIMIT(uv_lim), .GOOD_LIMIT(good_lim), .PHASE_OFFSET(phase));
   pls_host i_host (.MCLK(mclk), .RX_VALID(rx_valid), .RX_START(rx_start),
      .RX_BYTE(rx_byte), .RX_STOP(rx_stop), .TX_REQ(tx_req),
      .TX_BYTE(tx_byte), .CMD_ERR(cmd_err));
   function automatic logic [15:0] scale(input int p);
      return 16'((int'(strap) * p) / 100);
   endfunction
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask
   // one tick of slack each way: the first tick may be partial
   task automatic near(input int n, input int t);
      chk(16'(n >= (t - 1) * TC && n <= (t + 1) * TC + 3), 16'h0001);
   endtask
   task automatic span(input int b, input logic v, output int n);
      n = 0;
      while (st[b] !== v && n < 3000) begin
         @(posedge mclk);
         n++;
      end
   endtask
   task automatic t_defaults();
      logic [15:0] d;
      logic [15:0] e;
      for (int i = 0; i < NREG; i++) begin
         e = RESET_TAB[i];
         if (i == IDX_PHASE) e = {12'h000, addr[3:0]};
         if (i == IDX_OUT_OV) e = scale(115);
         if (i == IDX_OUT_UV) e = scale(80);
         if (i == IDX_GOOD) e = scale(90);
         i_host.rd(CODE_TAB[i], d);
         chk(d, e);
      end
      i_host.rd(8'h20, d);
      chk(d, 16'h1313);
      chk(good_lim, scale(90));
      chk(phase, {12'h000, addr[3:0]});
      chk(ov_lim, scale(115));
      chk(uv_lim, scale(80));
      $display("defaults done");
   endtask
   task automatic t_rw();
      logic [15:0] d;
      logic [15:0] w;
      logic err;
      for (int i = 0; i < NREG; i++) begin
         w = {CODE_TAB[i] ^ 8'hA5, CODE_TAB[i]};
         if (BYTE_WIDE[i]) w[15:8] = 8'h00;
         i_host.wr(CODE_TAB[i], w, BYTE_WIDE[i] ? 1 : 2, err);
         chk(16'(err), 16'h0000);
         i_host.rd(CODE_TAB[i], d);
         chk(d, w);
      end
      i_host.wr(8'h40, 16'h0011, 1, err);
      chk(16'(err), 16'h0001);
      chk(ov_lim, 16'hE540);
      i_host.wr(8'h20, 16'h0000, 1, err);
      chk(16'(err), 16'h0001);
      // unknown codes read back as all ones
      i_host.rd(8'h42, d);
      chk(d, 16'hFFFF);
      $display("read write done");
   endtask
   task automatic t_seq();
      logic err;
      int n;
      i_host.wr(8'h60, 16'hF801, 2, err);
      i_host.wr(8'h61, 16'h0001, 2, err);
      i_host.wr(8'h64, 16'hF001, 2, err);
      i_host.wr(8'h65, 16'h0002, 2, err);
      enable <= 1'b1;
      span(0, 1'b1, n);
      near(n, 8);
      span(0, 1'b0, n);
      near(n, 16);
      enable <= 1'b0;
      span(1, 1'b1, n);
      near(n, 4);
      span(1, 1'b0, n);
      near(n, 32);
      chk(16'(output_on), 16'h0000);
      enable <= 1'b1;
      repeat (10) @(posedge mclk);
      enable <= 1'b0;
      repeat (60) @(posedge mclk);
      chk(16'(output_on), 16'h0000);
      $display("sequencing done");
   endtask
   // second reset with new straps: defaults must follow them
   task automatic t_reset();
      logic [15:0] d;
      rst_n <= 1'b0;
      addr <= 7'h1A;
      strap <= 16'h1800;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(phase, {12'h000, addr[3:0]});
      chk(ov_lim, scale(115));
      chk(uv_lim, scale(80));
      chk(good_lim, scale(90));
      chk(16'(output_on), 16'h0000);
      i_host.rd(8'h41, d);
      chk(d, 16'h0080);
      i_host.rd(8'h60, d);
      chk(d, 16'hCA80);
      $display("reset done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      rst_n = 1'b0;
      enable = 1'b0;
      addr = 7'h25;
      strap = 16'h2000;
      mismatches = 0;
      checks = 0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      t_defaults();
      t_rw();
      t_seq();
      t_reset();
      test_done();
   end
   // about 900 cycles expected; wide margin for the timers
   initial begin
      repeat (30000) @(posedge mclk);
      mismatches++;
      test_done();
   end
endmodule
